// *** logic/aswd_sequencer.sv ***
// Functional notes
// - negative nibble picks pins 0-7; top bit set means ground, single-ended.
// - positive nibble picks pins 0-7, temp sensor 1000, supply 1001.
// - conversion clock is system clock divided by divider field plus one.
// - gain field bits 1:0 selects gain 0.5, 1, 2, 4.
// - configuration bit 2 reads zero, writes ignored.
// - result register holds last byte; unsigned single-ended, signed differential.
// - enable clear means shutdown; enable set means active and triggerable.
// - normal track mode tracks whenever enabled and not converting.
// - done flag sets on conversion end, stays until software clears.
// - busy write of one starts conversion only in start mode 000.
// - window flag sets on window match, stays until software clears.
// - start mode picks busy write, timer 0, timer 2, timer 1, or pin.
// - low-power mode internal triggers track three conversion clocks, then convert.
// - low-power pin mode tracks while pin low, converts on rising edge.
// - every result compared against both limits; match shown by window flag.
// - limit values decide inside-window or outside-window detection.
// - inside window single-ended: strictly above greater, strictly below less, unsigned.
// - differential mode compares results and limits as signed bytes.
// - busy reads one during conversion; its fall sets done flag.
// - conversion lasts eleven conversion clocks until result is written.
module aswd_sequencer
  import aswd_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       timer0_ovf,
  input  wire logic       timer1_ovf,
  input  wire logic       timer2_ovf,
  input  wire logic       external_start_input,
  input  wire logic [7:0] sar_result,
  output aswd_afe_s       afe,
  output logic            sar_clk_en
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // a > b, signed when differential
  function automatic logic above(input logic [7:0] a, input logic [7:0] b,
                                 input logic sgn);
    if (sgn) begin
      above = $signed(a) > $signed(b);
    end else begin
      above = a > b;
    end
  endfunction : above

  function automatic logic win_hit(input logic [7:0] r, input logic [7:0] gt,
                                   input logic [7:0] lt, input logic sgn);
    if (above(lt, gt, sgn)) begin
      win_hit = above(r, gt, sgn) && above(lt, r, sgn);
    end else begin
      win_hit = above(r, gt, sgn) || above(lt, r, sgn);
    end
  endfunction : win_hit

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]  channel_select;
  logic [7:0]  converter_config;
  logic [7:0]  conversion_result;
  logic [7:0]  greater_than_limit;
  logic [7:0]  less_than_limit;
  logic        converter_enable_bit;
  logic        track_mode_bit;
  logic        conversion_done_flag;
  logic        window_match_flag;
  logic [2:0]  start_mode_field;
  aswd_state_e state;
  logic [3:0]  tick_cnt;
  logic        ext_q;
  logic        sar_tick;

  logic wr_chan, wr_cfg, wr_res, wr_ctl, wr_gt, wr_lt;
  logic single_ended;
  logic busy;
  logic ext_rise;
  logic busy_kick;
  logic trigger;
  logic conv_finish;
  logic lp_done;
  logic result_hit;

  assign wr_chan      = sfr_wr && sfr_addr == ADDR_CHANNEL_SELECT;
  assign wr_cfg       = sfr_wr && sfr_addr == ADDR_CONV_CONFIG;
  assign wr_res       = sfr_wr && sfr_addr == ADDR_CONV_RESULT;
  assign wr_ctl       = sfr_wr && sfr_addr == ADDR_CONV_CONTROL;
  assign wr_gt        = sfr_wr && sfr_addr == ADDR_GT_LIMIT;
  assign wr_lt        = sfr_wr && sfr_addr == ADDR_LT_LIMIT;
  assign single_ended = channel_select[NEG_MSB];
  assign busy         = state != ST_IDLE;
  assign ext_rise     = external_start_input && !ext_q;
  assign busy_kick    = wr_ctl && sfr_wdata[CTL_BUSY];

  always_comb begin
    unique casez (start_mode_field)
      CM_BUSY_WRITE: trigger = busy_kick;
      CM_TIMER0:     trigger = timer0_ovf;
      CM_TIMER2:     trigger = timer2_ovf;
      CM_TIMER1:     trigger = timer1_ovf;
      3'b1??:        trigger = ext_rise;
    endcase
  end

  assign lp_done     = state == ST_LPTRACK && sar_tick
                       && tick_cnt == 4'(LP_TRACK_CLOCKS - 1);
  assign conv_finish = state == ST_CONVERT && sar_tick
                       && tick_cnt == 4'(CONV_CLOCKS - 1);
  assign result_hit  = win_hit(sar_result, greater_than_limit,
                               less_than_limit, !single_ended);

  ////////////////////////////////////////////////////////////////////////////
  // conversion clock

  aswd_clkdiv #(
    .W (5)
  ) u_div (
    .core_clk           (core_clk),
    .rst_n              (rst_n),
    .conv_clock_divider (converter_config[DIV_MSB:DIV_LSB]),
    .sar_tick           (sar_tick)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sar_clk_en <= 1'b0;
    end else begin
      sar_clk_en <= sar_tick && busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_select     <= RST_CHANNEL_SELECT;
      converter_config   <= RST_CONV_CONFIG;
      greater_than_limit <= RST_GT_LIMIT;
      less_than_limit    <= RST_LT_LIMIT;
    end else begin
      if (wr_chan) begin
        channel_select <= sfr_wdata;
      end
      if (wr_cfg) begin
        converter_config <= sfr_wdata & ~(8'h01 << CFG_RSV_BIT);
      end
      if (wr_gt) begin
        greater_than_limit <= sfr_wdata;
      end
      if (wr_lt) begin
        less_than_limit <= sfr_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_enable_bit <= RST_CONV_CONTROL[CTL_ENABLE];
      track_mode_bit       <= RST_CONV_CONTROL[CTL_TRACK];
      start_mode_field     <= RST_CONV_CONTROL[CTL_CM_MSB:CTL_CM_LSB];
    end else if (wr_ctl) begin
      converter_enable_bit <= sfr_wdata[CTL_ENABLE];
      track_mode_bit       <= sfr_wdata[CTL_TRACK];
      start_mode_field     <= sfr_wdata[CTL_CM_MSB:CTL_CM_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags: hardware set wins over software clear

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_done_flag <= RST_CONV_CONTROL[CTL_DONE];
    end else if (conv_finish) begin
      conversion_done_flag <= 1'b1;
    end else if (wr_ctl && !sfr_wdata[CTL_DONE]) begin
      conversion_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      window_match_flag <= RST_CONV_CONTROL[CTL_WIN];
    end else if (conv_finish && result_hit) begin
      window_match_flag <= 1'b1;
    end else if (wr_ctl && !sfr_wdata[CTL_WIN]) begin
      window_match_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result register

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_result <= RST_CONV_RESULT;
    end else if (conv_finish) begin
      conversion_result <= sar_result;
    end else if (wr_res) begin
      conversion_result <= sfr_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= external_start_input;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      tick_cnt <= '0;
    end else if (!converter_enable_bit) begin
      state    <= ST_IDLE;
      tick_cnt <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          tick_cnt <= '0;
          if (trigger) begin
            if (track_mode_bit && !start_mode_field[2]) begin
              state <= ST_LPTRACK;
            end else begin
              state <= ST_CONVERT;
            end
          end
        end
        ST_LPTRACK: begin
          if (lp_done) begin
            state    <= ST_CONVERT;
            tick_cnt <= '0;
          end else if (sar_tick) begin
            tick_cnt <= tick_cnt + 1'b1;
          end
        end
        ST_CONVERT: begin
          if (conv_finish) begin
            state    <= ST_IDLE;
            tick_cnt <= '0;
          end else if (sar_tick) begin
            tick_cnt <= tick_cnt + 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog front end controls

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      afe <= '0;
    end else begin
      afe.positive_channel_field <= channel_select[POS_MSB:POS_LSB];
      afe.negative_channel_field <= channel_select[NEG_MSB:NEG_LSB];
      afe.single_ended           <= single_ended;
      afe.gain_code              <= converter_config[GAIN_MSB:GAIN_LSB];
      afe.powered                <= converter_enable_bit;
      afe.converting             <= state == ST_CONVERT;
      if (!converter_enable_bit || state == ST_CONVERT) begin
        afe.tracking <= 1'b0;
      end else if (!track_mode_bit) begin
        afe.tracking <= 1'b1;
      end else if (start_mode_field[2]) begin
        afe.tracking <= !external_start_input;
      end else begin
        afe.tracking <= state == ST_LPTRACK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= '0;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_CHANNEL_SELECT: sfr_rdata <= channel_select;
        ADDR_CONV_CONFIG:    sfr_rdata <= converter_config;
        ADDR_CONV_RESULT:    sfr_rdata <= conversion_result;
        ADDR_GT_LIMIT:       sfr_rdata <= greater_than_limit;
        ADDR_LT_LIMIT:       sfr_rdata <= less_than_limit;
        ADDR_CONV_CONTROL:   sfr_rdata <= {converter_enable_bit, track_mode_bit,
                                           conversion_done_flag, busy,
                                           window_match_flag, start_mode_field};
        default:             sfr_rdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [3:0] chk_ticks;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_ticks <= '0;
    end else if (state == ST_IDLE || lp_done || conv_finish) begin
      chk_ticks <= '0;
    end else if (sar_tick) begin
      chk_ticks <= chk_ticks + 1'b1;
    end
  end

  sequence seq_busy_kick;
    state == ST_IDLE && converter_enable_bit && !track_mode_bit
      && start_mode_field == CM_BUSY_WRITE && busy_kick;
  endsequence

  sequence seq_conv_end;
    conv_finish ##1 !busy;
  endsequence

  chk_cfg_bit2_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    sfr_rd && sfr_addr == ADDR_CONV_CONFIG |=> !sfr_rdata[CFG_RSV_BIT])
    else $error("config bit 2 read as one");

  chk_busy_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    seq_busy_kick |=> state == ST_CONVERT ##1 afe.converting)
    else $error("busy write did not start conversion");

  chk_done_on_end: assert property (@(posedge core_clk) disable iff (!rst_n)
    seq_conv_end |-> conversion_done_flag)
    else $error("done flag not set when busy fell");

  chk_done_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    conversion_done_flag && !(wr_ctl && !sfr_wdata[CTL_DONE]) |=> conversion_done_flag)
    else $error("done flag dropped without software clear");

  chk_win_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
    window_match_flag && !(wr_ctl && !sfr_wdata[CTL_WIN]) |=> window_match_flag)
    else $error("window flag dropped without software clear");

  chk_win_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    conv_finish && result_hit |=> window_match_flag && conversion_result == $past(sar_result))
    else $error("window match not flagged");

  chk_lp_track_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    lp_done |-> chk_ticks == 4'(LP_TRACK_CLOCKS - 1))
    else $error("low-power tracking not three conversion clocks");

  chk_conv_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    conv_finish |-> chk_ticks == 4'(CONV_CLOCKS - 1))
    else $error("conversion not eleven conversion clocks");

  chk_shutdown: assert property (@(posedge core_clk) disable iff (!rst_n)
    !converter_enable_bit |=> !busy && !afe.powered && !afe.tracking)
    else $error("converter active while disabled");

  chk_normal_track: assert property (@(posedge core_clk) disable iff (!rst_n)
    converter_enable_bit && !track_mode_bit && state != ST_CONVERT |=> afe.tracking)
    else $error("normal mode not tracking while idle");

endmodule : aswd_sequencer

// *** logic/aswd_pkg.sv ***
package aswd_pkg;

  // register addresses on the core register bus
  localparam logic [7:0] ADDR_CHANNEL_SELECT = 8'hBB;
  localparam logic [7:0] ADDR_CONV_CONFIG    = 8'hBC;
  localparam logic [7:0] ADDR_CONV_RESULT    = 8'hBE;
  localparam logic [7:0] ADDR_CONV_CONTROL   = 8'hE8;
  localparam logic [7:0] ADDR_GT_LIMIT       = 8'hC4;
  localparam logic [7:0] ADDR_LT_LIMIT       = 8'hC6;

  // reset values
  localparam logic [7:0] RST_CHANNEL_SELECT  = 8'h00;
  localparam logic [7:0] RST_CONV_CONFIG     = 8'hF8;
  localparam logic [7:0] RST_CONV_RESULT     = 8'h00;
  localparam logic [7:0] RST_CONV_CONTROL    = 8'h00;
  localparam logic [7:0] RST_GT_LIMIT        = 8'hFF;
  localparam logic [7:0] RST_LT_LIMIT        = 8'h00;

  // channel_select fields
  localparam int NEG_MSB = 7;
  localparam int NEG_LSB = 4;
  localparam int POS_MSB = 3;
  localparam int POS_LSB = 0;

  // converter_config fields
  localparam int DIV_MSB     = 7;
  localparam int DIV_LSB     = 3;
  localparam int CFG_RSV_BIT = 2;
  localparam int GAIN_MSB    = 1;
  localparam int GAIN_LSB    = 0;

  // converter_control fields
  localparam int CTL_ENABLE = 7;
  localparam int CTL_TRACK  = 6;
  localparam int CTL_DONE   = 5;
  localparam int CTL_BUSY   = 4;
  localparam int CTL_WIN    = 3;
  localparam int CTL_CM_MSB = 2;
  localparam int CTL_CM_LSB = 0;

  // start_mode_field codes
  localparam logic [2:0] CM_BUSY_WRITE = 3'h0;
  localparam logic [2:0] CM_TIMER0     = 3'h1;
  localparam logic [2:0] CM_TIMER2     = 3'h2;
  localparam logic [2:0] CM_TIMER1     = 3'h3;

  // timing in conversion clocks
  localparam int LP_TRACK_CLOCKS = 3;
  localparam int CONV_CLOCKS     = 11;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LPTRACK,
    ST_CONVERT
  } aswd_state_e;

  // controls toward the analog mux, amplifier and converter
  typedef struct packed {
    logic [3:0] positive_channel_field;
    logic [3:0] negative_channel_field;
    logic       single_ended;
    logic [1:0] gain_code;
    logic       powered;
    logic       tracking;
    logic       converting;
  } aswd_afe_s;

endpackage : aswd_pkg

// *** logic/aswd_clkdiv.sv ***
module aswd_clkdiv
  import aswd_pkg::*;
#(
  parameter int W = 5
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] conv_clock_divider,
  output logic              sar_tick
);

  logic [W-1:0] cnt;

  // one tick every conv_clock_divider + 1 system clocks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= '0;
      sar_tick <= 1'b0;
    end else if (cnt >= conv_clock_divider) begin
      cnt      <= '0;
      sar_tick <= 1'b1;
    end else begin
      cnt      <= cnt + 1'b1;
      sar_tick <= 1'b0;
    end
  end

endmodule : aswd_clkdiv

// *** testbench/aswd_sar_model.sv ***
module aswd_sar_model
  import aswd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire aswd_afe_s   afe,
  input  wire logic        sar_clk_en,
  input  wire logic [7:0]  level,
  output logic      [7:0]  sar_result,
  output logic      [15:0] ticks,
  output logic      [7:0]  gap
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] since;

  // result lines only hold a code while converting, garbage otherwise
  assign sar_result = afe.converting ? level : ~level;

  ////////////////////////////////////////////////////////////////////////////
  // count conversion clocks and the spacing between them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ticks <= '0;
      since <= '0;
      gap   <= '0;
    end else if (sar_clk_en) begin
      ticks <= ticks + 16'h0001;
      gap   <= since + 8'h01;
      since <= '0;
    end else begin
      since <= since + 8'h01;
    end
  end
endmodule : aswd_sar_model

// *** testbench/adc_sequencer_window_detect_bench.sv ***
module adc_sequencer_window_detect_bench
  import aswd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        core_clk;
  logic        rst_n;
  logic        sfr_wr;
  logic        sfr_rd;
  logic        timer0_ovf;
  logic        timer1_ovf;
  logic        timer2_ovf;
  logic        external_start_input;
  logic        sar_clk_en;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic [7:0]  sar_result;
  logic [7:0]  level;
  logic [7:0]  gap;
  logic [7:0]  rv;
  logic [15:0] ticks;
  logic [15:0] t0;
  aswd_afe_s   afe;
  int          errors;
  int          checks;

  // rows: channel, greater limit, less limit, result; flag expected per bit
  localparam logic [31:0] win_rows [11] = '{
    32'h8010_2010, 32'h8010_2011, 32'h8010_201F, 32'h8010_2020, 32'h8020_100F,
    32'h8020_1015, 32'h8020_1021, 32'h00FF_1000, 32'h00F0_10F8, 32'h0010_F080,
    32'h0010_F0F8};
  localparam logic [10:0] win_flag = 11'h3D6;
  localparam logic [7:0] reg_addr [7] = '{ADDR_CHANNEL_SELECT, ADDR_CONV_CONFIG,
    ADDR_CONV_RESULT, ADDR_CONV_CONTROL, ADDR_GT_LIMIT, ADDR_LT_LIMIT, 8'h00};
  localparam logic [7:0] reg_rst [7] = '{RST_CHANNEL_SELECT, RST_CONV_CONFIG,
    RST_CONV_RESULT, RST_CONV_CONTROL, RST_GT_LIMIT, RST_LT_LIMIT, 8'h00};

  aswd_sequencer i_dut (
    .core_clk             (core_clk),
    .rst_n                (rst_n),
    .sfr_addr             (sfr_addr),
    .sfr_wr               (sfr_wr),
    .sfr_rd               (sfr_rd),
    .sfr_wdata            (sfr_wdata),
    .sfr_rdata            (sfr_rdata),
    .timer0_ovf           (timer0_ovf),
    .timer1_ovf           (timer1_ovf),
    .timer2_ovf           (timer2_ovf),
    .external_start_input (external_start_input),
    .sar_result           (sar_result),
    .afe                  (afe),
    .sar_clk_en           (sar_clk_en)
  );

  aswd_sar_model i_sar (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .afe        (afe),
    .sar_clk_en (sar_clk_en),
    .level      (level),
    .sar_result (sar_result),
    .ticks      (ticks),
    .gap        (gap)
  );

  always #20 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    @(negedge core_clk);
    rv = sfr_rdata;
  endtask : rd

  task automatic wait_done;
    int n;
    n = 0;
    rd(ADDR_CONV_CONTROL);
    while (rv[CTL_DONE] !== 1'b1 && n < 100) begin
      rd(ADDR_CONV_CONTROL);
      n++;
    end
    chk(rv[CTL_DONE], 1'b1);
  endtask : wait_done

  task automatic fire(input int k, input logic [7:0] cm);
    @(negedge core_clk);
    case (k)
      0: sfr_wr = 1'b0;
      1: timer0_ovf = 1'b1;
      2: timer2_ovf = 1'b1;
      3: timer1_ovf = 1'b1;
      default: external_start_input = 1'b1;
    endcase
    @(negedge core_clk);
    {timer0_ovf, timer1_ovf, timer2_ovf, external_start_input} = 4'h0;
    if (k == 0) begin
      wr(ADDR_CONV_CONTROL, cm | 8'h10);
    end
  endtask : fire

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    for (int i = 0; i < 7; i++) begin
      rd(reg_addr[i]);
      chk(rv, reg_rst[i]);
    end
    wr(ADDR_CONV_CONFIG, 8'hFF);
    rd(ADDR_CONV_CONFIG);
    chk(rv, 8'hFB);
    chk(afe.gain_code, 2'h3);
    wr(ADDR_CONV_CONFIG, 8'h00);
    wr(ADDR_CHANNEL_SELECT, 8'h79);
    @(negedge core_clk);
    chk({afe.positive_channel_field, afe.negative_channel_field, afe.single_ended},
        9'h12E);
    wr(ADDR_CHANNEL_SELECT, 8'h8A);
    @(negedge core_clk);
    chk({afe.positive_channel_field, afe.single_ended, afe.gain_code}, 7'h54);
  endtask : t_regs

  task automatic t_enable;
    chk(afe.powered, 1'b0);
    wr(ADDR_CONV_CONTROL, 8'h10);
    repeat (20) @(negedge core_clk);
    rd(ADDR_CONV_CONTROL);
    chk(rv[CTL_DONE], 1'b0);
    wr(ADDR_CONV_CONTROL, 8'h80);
    @(negedge core_clk);
    chk({afe.powered, afe.tracking, afe.converting}, 3'h6);
  endtask : t_enable

  task automatic t_busy(input logic [7:0] cfg, input logic [7:0] lv);
    wr(ADDR_CONV_CONFIG, cfg);
    level = lv;
    t0 = ticks;
    wr(ADDR_CONV_CONTROL, 8'h90);
    wait_done();
    chk(ticks - t0, 16'd11);
    chk(gap, {3'h0, cfg[7:3]} + 8'h01);
    rd(ADDR_CONV_RESULT);
    chk(rv, lv);
  endtask : t_busy

  task automatic t_modes;
    logic [7:0] cm;
    for (int m = 1; m < 5; m++) begin
      cm = 8'h80 | m[7:0];
      wr(ADDR_CONV_CONTROL, cm);
      fire(0, cm);
      fire((m % 4) + 1, cm);
      repeat (20) @(negedge core_clk);
      rd(ADDR_CONV_CONTROL);
      chk(rv[CTL_DONE], 1'b0);
      t0 = ticks;
      fire(m, cm);
      wait_done();
      chk(ticks - t0, 16'd11);
    end
  endtask : t_modes

  task automatic t_lowpower;
    // busy kick is judged against the stored mode, so set it first
    wr(ADDR_CONV_CONTROL, 8'hC0);
    t0 = ticks;
    wr(ADDR_CONV_CONTROL, 8'hD0);
    wait_done();
    chk(ticks - t0, 16'd14);
    wr(ADDR_CONV_CONTROL, 8'hC4);
    repeat (2) @(negedge core_clk);
    chk({afe.tracking, afe.converting}, 2'h2);
    t0 = ticks;
    // low for the whole tracking span, then hold high until done
    external_start_input = 1'b1;
    wait_done();
    chk(ticks - t0, 16'd11);
    chk(afe.tracking, 1'b0);
    external_start_input = 1'b0;
  endtask : t_lowpower

  task automatic t_window;
    logic [31:0] w;
    // leave pin mode so the busy kick below is a trigger
    wr(ADDR_CONV_CONTROL, 8'h80);
    for (int i = 0; i < 11; i++) begin
      w = win_rows[i];
      wr(ADDR_CHANNEL_SELECT, w[31:24]);
      wr(ADDR_GT_LIMIT, w[23:16]);
      wr(ADDR_LT_LIMIT, w[15:8]);
      level = w[7:0];
      wr(ADDR_CONV_CONTROL, 8'h90);
      wait_done();
      chk(rv[CTL_WIN], win_flag[i]);
    end
  endtask : t_window

  task automatic t_flags;
    wr(ADDR_CONV_CONTROL, 8'hA8);
    rd(ADDR_CONV_CONTROL);
    chk(rv & 8'hE8, 8'hA0);
    wr(ADDR_CONV_CONTROL, 8'h80);
    wr(ADDR_CONV_CONTROL, 8'hA8);
    rd(ADDR_CONV_CONTROL);
    chk(rv & 8'hE8, 8'h80);
  endtask : t_flags

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    {sfr_wr, sfr_rd, timer0_ovf, timer1_ovf, timer2_ovf} = 5'h00;
    external_start_input = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    level = 8'h00;
    errors = 0;
    checks = 0;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    t_regs();
    t_enable();
    t_busy(8'h00, 8'h5A);
    t_busy(8'h08, 8'hA5);
    wr(ADDR_CONV_CONFIG, 8'h00);
    t_modes();
    t_lowpower();
    t_window();
    t_flags();
    give_verdict();
  end

  // whole run needs several hundred cycles
  initial begin
    #(40 * 20000);
    errors++;
    give_verdict();
  end
endmodule : adc_sequencer_window_detect_bench
